// *** src/baud_rate_divider.sv ***
// Purpose: divide crystal ticks down to the serial bit rate
// Assumes: ref_tick_i is one cycle per crystal period
// Notes:   setting only taken on load_i, i.e. at a character start
`timescale 1ns/1ps
`default_nettype none
module baud_rate_divider (
	// clock and control
	input  wire logic                           clk_i,
	input  wire logic                           rst_i,
	input  wire logic                           ce_i,
	// rate control
	input  wire logic                           ref_tick_i,
	input  wire logic                           load_i,
	input  wire logic [clock_cfg_pkg::REG_W-1:0] setting_i,
	// bit timing
	output logic                                bit_tick_o
);
	import clock_cfg_pkg::*;

	logic [REG_W-1:0]      active_q;
	logic [BAUD_DIV_W-1:0] cnt_q;
	logic [BAUD_DIV_W-1:0] div_d;
	logic [BAUD_DIV_W-1:0] mant_w;
	logic [2:0]            exp_w;

	always_comb begin
		exp_w  = active_q[EXP_MSB:EXP_LSB];
		mant_w = BAUD_DIV_W'(active_q[MANT_MSB:MANT_LSB]);
		if (exp_w == EXP_ZERO) begin
			div_d = mant_w + DIV_ONE; // RL1
		end else begin
			div_d = (mant_w + MANT_EXT_OFFSET) << (exp_w - EXP_ONE); // RL2
		end
	end

	// new rate waits for the next frame start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			active_q <= RST_SERIAL_RATE;
		end else if (ce_i && load_i) begin
			active_q <= setting_i; // RL15
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q      <= '0;
			bit_tick_o <= 1'b0;
		end else if (ce_i) begin
			bit_tick_o <= 1'b0;
			if (load_i) begin
				cnt_q <= '0;
			end else if (ref_tick_i) begin
				if (cnt_q == div_d - DIV_ONE) begin
					cnt_q      <= '0;
					bit_tick_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + DIV_ONE;
				end
			end
		end
	end

	AST_BAUD_TICK_AT_DIV: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
		ce_i && ref_tick_i && !load_i && cnt_q == div_d - DIV_ONE |=> bit_tick_o)
		else $error("bit tick missing at end of divide");
	AST_BAUD_NO_EARLY: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
		ce_i && !(ref_tick_i && !load_i && cnt_q == div_d - DIV_ONE) |=> !bit_tick_o)
		else $error("bit tick before divide count");
endmodule
`default_nettype wire

// *** src/clock_cfg_pkg.sv ***
// Purpose: shared constants for the clock configuration and serial rate block
// Assumes: 8-bit registers on an 8-bit classic Wishbone slave
// Notes:   crystal reference is sampled as a level on the 250 MHz system clock
package clock_cfg_pkg;
	localparam int REG_W = 8;
	localparam int BAUD_DIV_W = 13;
	localparam int SEL_W = 4;
	localparam int FB_DIV_W = 5;
	localparam int TIMER_N = 4;

	// register offsets
	localparam logic [REG_W-1:0] ADR_SERIAL_RATE   = 8'h3B;
	localparam logic [REG_W-1:0] ADR_SLOW_OSC_TRIM = 8'h3C;
	localparam logic [REG_W-1:0] ADR_PLL_CTRL      = 8'h3D;
	localparam logic [REG_W-1:0] ADR_PLL_OUT_DIV   = 8'h3E;
	localparam logic [REG_W-1:0] ADR_STATUS        = 8'h80;

	// reset values
	localparam logic [REG_W-1:0] RST_SERIAL_RATE   = 8'h7A;
	localparam logic [REG_W-1:0] RST_SLOW_OSC_TRIM = 8'h00;
	localparam logic [REG_W-1:0] RST_PLL_CTRL      = 8'h00;
	localparam logic [REG_W-1:0] RST_PLL_OUT_DIV   = 8'h08;

	// serial rate fields
	localparam int EXP_MSB  = 7;
	localparam int EXP_LSB  = 5;
	localparam int MANT_MSB = 4;
	localparam int MANT_LSB = 0;
	localparam logic [BAUD_DIV_W-1:0] MANT_EXT_OFFSET = 13'h0021;
	localparam logic [BAUD_DIV_W-1:0] DIV_ONE         = 13'h0001;
	localparam logic [2:0]            EXP_ZERO        = 3'h0;
	localparam logic [2:0]            EXP_ONE         = 3'h1;

	// pll control fields
	localparam int SEL_MSB    = 7;
	localparam int SEL_LSB    = 4;
	localparam int PIN_EN_BIT = 3;
	localparam int PD_BIT     = 2;
	localparam int FB_MSB     = 1;
	localparam int FB_LSB     = 0;
	localparam logic [1:0]          FB_CODE_27 = 2'h1;
	localparam logic [1:0]          FB_CODE_28 = 2'h2;
	localparam logic [FB_DIV_W-1:0] FB_DIV_23  = 5'h17;
	localparam logic [FB_DIV_W-1:0] FB_DIV_27  = 5'h1B;
	localparam logic [FB_DIV_W-1:0] FB_DIV_28  = 5'h1C;

	// clock pin source codes
	localparam logic [SEL_W-1:0] SEL_GPIO      = 4'h0;
	localparam logic [SEL_W-1:0] SEL_PLL       = 4'h1;
	localparam logic [SEL_W-1:0] SEL_HOLD_LOW  = 4'h2;
	localparam logic [SEL_W-1:0] SEL_HOLD_HIGH = 4'h3;
	localparam logic [SEL_W-1:0] SEL_XTAL      = 4'h4;
	localparam logic [SEL_W-1:0] SEL_XTAL_DIV2 = 4'h5;
	localparam logic [SEL_W-1:0] SEL_XTAL_DIV4 = 4'h6;
	localparam logic [SEL_W-1:0] SEL_XTAL_DIV8 = 4'h7;
	localparam logic [SEL_W-1:0] SEL_OVF_0     = 4'h8;
	localparam logic [SEL_W-1:0] SEL_OVF_1     = 4'h9;
	localparam logic [SEL_W-1:0] SEL_OVF_2     = 4'hA;
	localparam logic [SEL_W-1:0] SEL_OVF_3     = 4'hB;

	// serial framing
	localparam logic [3:0] FRAME_BITS = 4'hA;
	localparam logic [3:0] BIT_ONE    = 4'h1;
	localparam logic       START_LVL  = 1'b0;
	localparam logic       STOP_LVL   = 1'b1;

	// status bits
	localparam int ST_TX_BUSY = 0;
	localparam int ST_PIN     = 1;
	localparam int ST_PIN_OE  = 2;

	typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
endpackage

// *** src/clock_config_and_baud_gen.sv ***
// Purpose: clock configuration, serial bit rate and clock pin control
// Assumes: xtal_i is the 27.12 MHz crystal level, synchronous to clk_i
// Notes:   analog pll and slow oscillator sit outside; this drives their settings
// Function
// [RL1] exponent zero: rate is crystal over mantissa+1
// [RL2] else crystal over mantissa+33, over 2^(exponent-1)
// [RL3] frame: start, eight data, stop, no parity
// [RL4] host keeps rate at or below 1228.8 kbit/s
// [RL5] serial rate register resets to 7Ah
// [RL6] host uses table values for standard rates
// [RL7] larger trim gives slower oscillator
// [RL8] clock out: crystal times feedback, halved, over output
// [RL9] feedback code gives 23, 27, 28, 23
// [RL10] output divider divides by its value, 8..254
// [RL11] codes 0-3: io, pll, low, high
// [RL12] codes 4-7: crystal, half, quarter, eighth
// [RL13] codes 8-B toggle pin on timer overflow
// [RL14] control byte: select, enable, power down, feedback
// [RL15] new rate applies at next character start
`timescale 1ns/1ps
`default_nettype none
module clock_config_and_baud_gen (
	// clock and control
	input  wire logic                                clk_i,
	input  wire logic                                rst_i,
	input  wire logic                                ce_i,
	// wishbone slave
	input  wire logic                                wb_cyc_i,
	input  wire logic                                wb_stb_i,
	input  wire logic                                wb_we_i,
	input  wire logic                                wb_sel_i,
	input  wire logic [clock_cfg_pkg::REG_W-1:0]     wb_adr_i,
	input  wire logic [clock_cfg_pkg::REG_W-1:0]     wb_dat_i,
	output logic      [clock_cfg_pkg::REG_W-1:0]     wb_dat_o,
	output logic                                     wb_ack_o,
	// clock sources
	input  wire logic                                xtal_i,
	input  wire logic                                pll_clk_i,
	input  wire logic [clock_cfg_pkg::TIMER_N-1:0]   timer_ovf_i,
	input  wire logic                                gpio_out_i,
	input  wire logic                                gpio_oe_i,
	// serial transmit
	input  wire logic [clock_cfg_pkg::REG_W-1:0]     tx_data_i,
	input  wire logic                                tx_valid_i,
	output logic                                     tx_ready_o,
	output logic                                     txd_o,
	// clock pin
	output logic                                     clock_pin_o,
	output logic                                     clock_pin_oe_o,
	// analog settings
	output logic                                     pll_power_down_o,
	output logic      [clock_cfg_pkg::FB_DIV_W-1:0]  pll_feedback_divide_o,
	output logic      [clock_cfg_pkg::REG_W-1:0]     pll_output_divide_o,
	output logic      [clock_cfg_pkg::REG_W-1:0]     slow_osc_trim_o,
	output logic      [clock_cfg_pkg::REG_W-1:0]     slow_osc_speed_o
);
	import clock_cfg_pkg::*;

	logic [REG_W-1:0] serial_rate_setting_q;
	logic [REG_W-1:0] slow_osc_trim_value_q;
	logic [REG_W-1:0] pll_and_clock_pin_control_q;
	logic [REG_W-1:0] pll_output_divider_q;
	logic [REG_W-1:0] rdata_d;
	logic [REG_W-1:0] status_w;
	logic             bus_req;
	logic             bus_wr;
	logic             xtal_prev_q;
	logic             ref_tick;
	logic             bit_tick;
	logic             tx_accept;
	tx_state_t        tx_state_q;
	logic [3:0]       tx_bits_q;
	logic [REG_W:0]   tx_shift_q;

	assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign bus_wr  = bus_req && wb_we_i && wb_sel_i;

	// register file
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_rate_setting_q       <= RST_SERIAL_RATE; // RL5
			slow_osc_trim_value_q       <= RST_SLOW_OSC_TRIM;
			pll_and_clock_pin_control_q <= RST_PLL_CTRL;
			pll_output_divider_q        <= RST_PLL_OUT_DIV;
		end else if (ce_i && bus_wr) begin
			unique case (wb_adr_i)
				ADR_SERIAL_RATE:   serial_rate_setting_q       <= wb_dat_i;
				ADR_SLOW_OSC_TRIM: slow_osc_trim_value_q       <= wb_dat_i;
				ADR_PLL_CTRL:      pll_and_clock_pin_control_q <= wb_dat_i; // RL14
				ADR_PLL_OUT_DIV:   pll_output_divider_q        <= wb_dat_i; // RL10
				default:           ;
			endcase
		end
	end

	always_comb begin
		status_w             = '0;
		status_w[ST_TX_BUSY] = (tx_state_q == TX_SEND);
		status_w[ST_PIN]     = clock_pin_o;
		status_w[ST_PIN_OE]  = clock_pin_oe_o;
		unique case (wb_adr_i)
			ADR_SERIAL_RATE:   rdata_d = serial_rate_setting_q;
			ADR_SLOW_OSC_TRIM: rdata_d = slow_osc_trim_value_q;
			ADR_PLL_CTRL:      rdata_d = pll_and_clock_pin_control_q;
			ADR_PLL_OUT_DIV:   rdata_d = pll_output_divider_q;
			ADR_STATUS:        rdata_d = status_w;
			default:           rdata_d = '0;
		endcase
	end

	// ack one cycle after the strobe; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end else if (ce_i) begin
			wb_ack_o <= bus_req;
			if (bus_req) begin
				wb_dat_o <= rdata_d;
			end
		end
	end

	// crystal rising edge marks one reference period
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xtal_prev_q <= 1'b0;
		end else if (ce_i) begin
			xtal_prev_q <= xtal_i;
		end
	end
	assign ref_tick = xtal_i && !xtal_prev_q;

	// rate latched only when a character starts
	assign tx_accept = (tx_state_q == TX_IDLE) && tx_valid_i;

	baud_rate_divider u_baud (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.ce_i       (ce_i),
		.ref_tick_i (ref_tick),
		.load_i     (tx_accept), // RL15
		.setting_i  (serial_rate_setting_q),
		.bit_tick_o (bit_tick)
	);

	// transmitter: start bit, 8 data lsb first, stop bit
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_q <= TX_IDLE;
			tx_bits_q  <= '0;
			tx_shift_q <= '0;
			txd_o      <= STOP_LVL;
			tx_ready_o <= 1'b1;
		end else if (ce_i) begin
			unique case (tx_state_q)
				TX_IDLE: begin
					if (tx_valid_i) begin
						tx_state_q <= TX_SEND;
						tx_shift_q <= {STOP_LVL, tx_data_i}; // RL3
						tx_bits_q  <= '0;
						txd_o      <= START_LVL; // RL3
						tx_ready_o <= 1'b0;
					end
				end
				TX_SEND: begin
					if (bit_tick) begin
						if (tx_bits_q == FRAME_BITS - BIT_ONE) begin
							tx_state_q <= TX_IDLE; // RL3
							tx_ready_o <= 1'b1;
						end else begin
							txd_o      <= tx_shift_q[0];
							tx_shift_q <= tx_shift_q >> 1;
							tx_bits_q  <= tx_bits_q + BIT_ONE;
						end
					end
				end
			endcase
		end
	end

	clock_pin_mux u_pin (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.ce_i        (ce_i),
		.xtal_i      (xtal_i),
		.ref_tick_i  (ref_tick),
		.pll_clk_i   (pll_clk_i),
		.timer_ovf_i (timer_ovf_i),
		.gpio_out_i  (gpio_out_i),
		.gpio_oe_i   (gpio_oe_i),
		.select_i    (pll_and_clock_pin_control_q[SEL_MSB:SEL_LSB]), // RL14
		.enable_i    (pll_and_clock_pin_control_q[PIN_EN_BIT]), // RL14
		.pin_o       (clock_pin_o),
		.pin_oe_o    (clock_pin_oe_o)
	);

	// analog pll and oscillator settings
	assign pll_power_down_o    = pll_and_clock_pin_control_q[PD_BIT]; // RL14
	assign pll_output_divide_o = pll_output_divider_q; // RL8
	assign slow_osc_trim_o     = slow_osc_trim_value_q;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pll_feedback_divide_o <= FB_DIV_23;
			slow_osc_speed_o      <= ~RST_SLOW_OSC_TRIM;
		end else if (ce_i) begin
			// speed code falls as trim rises
			slow_osc_speed_o <= ~slow_osc_trim_value_q; // RL7
			unique case (pll_and_clock_pin_control_q[FB_MSB:FB_LSB])
				FB_CODE_27: pll_feedback_divide_o <= FB_DIV_27; // RL9
				FB_CODE_28: pll_feedback_divide_o <= FB_DIV_28; // RL9
				default:    pll_feedback_divide_o <= FB_DIV_23; // RL9
			endcase
		end
	end

	sequence s_tx_start;
		ce_i && tx_accept;
	endsequence
	sequence s_tx_last_tick;
		ce_i && tx_state_q == TX_SEND && bit_tick && tx_bits_q == FRAME_BITS - BIT_ONE;
	endsequence

	AST_ACK_ONE_CYCLE: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
		ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 (!wb_ack_o || !ce_i))
		else $error("bus ack not a single pulse after strobe");
	AST_TX_START_BIT: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
		s_tx_start |=> txd_o == START_LVL && !tx_ready_o)
		else $error("start bit not driven");
	AST_TX_STOP_END: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
		s_tx_last_tick |=> txd_o == STOP_LVL && tx_ready_o)
		else $error("frame did not end on stop bit");
	AST_TX_STABLE: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
		tx_state_q == TX_SEND && !bit_tick |=> $stable(txd_o))
		else $error("line changed between bit ticks");
	AST_FB_DIV_27: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
		ce_i && pll_and_clock_pin_control_q[FB_MSB:FB_LSB] == FB_CODE_27
		|=> pll_feedback_divide_o == FB_DIV_27)
		else $error("feedback divide for code 1 wrong");
	AST_TRIM_INVERSE: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
		ce_i |=> slow_osc_speed_o == ~$past(slow_osc_trim_value_q))
		else $error("oscillator speed not inverse of trim");
endmodule
`default_nettype wire

// *** src/clock_pin_mux.sv ***
// Purpose: select the source that drives the clock output pin
// Assumes: timer overflows are one-cycle pulses on clk_i
// Notes:   reserved select codes leave the pin undriven
`timescale 1ns/1ps
`default_nettype none
module clock_pin_mux (
	// clock and control
	input  wire logic                              clk_i,
	input  wire logic                              rst_i,
	input  wire logic                              ce_i,
	// sources
	input  wire logic                              xtal_i,
	input  wire logic                              ref_tick_i,
	input  wire logic                              pll_clk_i,
	input  wire logic [clock_cfg_pkg::TIMER_N-1:0] timer_ovf_i,
	input  wire logic                              gpio_out_i,
	input  wire logic                              gpio_oe_i,
	// selection
	input  wire logic [clock_cfg_pkg::SEL_W-1:0]   select_i,
	input  wire logic                              enable_i,
	// pin
	output logic                                   pin_o,
	output logic                                   pin_oe_o
);
	import clock_cfg_pkg::*;

	logic [2:0] xdiv_q;
	logic       toggle_q;
	logic       timer_sel;
	logic       pin_d;
	logic       oe_d;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xdiv_q <= '0;
		end else if (ce_i && ref_tick_i) begin
			xdiv_q <= xdiv_q + 3'h1;
		end
	end

	assign timer_sel = (select_i >= SEL_OVF_0) && (select_i <= SEL_OVF_3);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			toggle_q <= 1'b0;
		end else if (ce_i && timer_sel && timer_ovf_i[select_i[1:0]]) begin
			toggle_q <= ~toggle_q; // RL13
		end
	end

	always_comb begin
		pin_d = 1'b0;
		oe_d  = enable_i;
		unique case (select_i)
			SEL_GPIO: begin
				pin_d = gpio_out_i; // RL11
				oe_d  = gpio_oe_i;
			end
			SEL_PLL:       pin_d = pll_clk_i; // RL11
			SEL_HOLD_LOW:  pin_d = 1'b0; // RL11
			SEL_HOLD_HIGH: pin_d = 1'b1; // RL11
			SEL_XTAL:      pin_d = xtal_i; // RL12
			SEL_XTAL_DIV2: pin_d = xdiv_q[0]; // RL12
			SEL_XTAL_DIV4: pin_d = xdiv_q[1]; // RL12
			SEL_XTAL_DIV8: pin_d = xdiv_q[2]; // RL12
			SEL_OVF_0, SEL_OVF_1, SEL_OVF_2, SEL_OVF_3: pin_d = toggle_q; // RL13
			default: begin
				pin_d = 1'b0;
				oe_d  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_o    <= 1'b0;
			pin_oe_o <= 1'b0;
		end else if (ce_i) begin
			pin_o    <= pin_d;
			pin_oe_o <= oe_d;
		end
	end

	AST_PIN_HOLD_LOW: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
		ce_i && select_i == SEL_HOLD_LOW |=> !pin_o)
		else $error("pin not held low");
	AST_PIN_HOLD_HIGH: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
		ce_i && select_i == SEL_HOLD_HIGH |=> pin_o)
		else $error("pin not held high");
	AST_TIMER_TOGGLE: assert property (@(posedge clk_i) disable iff (rst_i) // RL13
		ce_i && select_i == SEL_OVF_2 && timer_ovf_i[2] |=> toggle_q != $past(toggle_q))
		else $error("timer overflow did not toggle pin");
	AST_PIN_DISABLED: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
		ce_i && select_i != SEL_GPIO && !enable_i |=> !pin_oe_o)
		else $error("pin driven while disabled");
endmodule
`default_nettype wire

// *** tb/clock_config_and_baud_gen_bench.sv ***
// Purpose: self-checking bench for clock configuration and serial rate block
// Assumes: crystal stand-in rises every 2 clk_i cycles, so one tick = 2 cycles
// Notes:   start bit length allows two cycles of divider phase slack
`timescale 1ns/1ps
`default_nettype none
module clock_config_and_baud_gen_bench;
	import clock_cfg_pkg::*;
	logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i;
	logic [7:0]  wb_adr_i, wb_dat_i, wb_dat_o, tx_data_i, rd, prev_speed;
	logic        wb_ack_o, xtal_i, pll_clk_i, gpio_out_i, gpio_oe_i;
	logic [3:0]  timer_ovf_i;
	logic        tx_valid_i, tx_ready_o, txd_o, clock_pin_o, clock_pin_oe_o;
	logic        pll_power_down_o, rx_done, stop_ok, p;
	logic [4:0]  fb_div;
	logic [7:0]  out_div, trim, speed, rx_byte;
	logic [15:0] bit_cycles, start_len;
	logic [1:0]  pll_cnt;
	int          n_errors, n_compared, n, d;
	logic [7:0]  rates [4] = '{8'h15, 8'h1C, 8'h21, 8'h41};
	logic [4:0]  fb_exp [4] = '{5'h17, 5'h1B, 5'h1C, 5'h17};
	logic [3:0]  clk_codes [5] = '{4'h1, 4'h4, 4'h5, 4'h6, 4'h7};
	int          clk_rises [5] = '{8, 32, 16, 8, 4};

	clock_config_and_baud_gen u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
		.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.xtal_i(xtal_i), .pll_clk_i(pll_clk_i), .timer_ovf_i(timer_ovf_i),
		.gpio_out_i(gpio_out_i), .gpio_oe_i(gpio_oe_i), .tx_data_i(tx_data_i),
		.tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .txd_o(txd_o),
		.clock_pin_o(clock_pin_o), .clock_pin_oe_o(clock_pin_oe_o),
		.pll_power_down_o(pll_power_down_o), .pll_feedback_divide_o(fb_div),
		.pll_output_divide_o(out_div), .slow_osc_trim_o(trim), .slow_osc_speed_o(speed));
	serial_host_model u_host (.clk_i(clk_i), .rst_i(rst_i), .txd_i(txd_o),
		.bit_cycles_i(bit_cycles), .rx_byte_o(rx_byte), .rx_done_o(rx_done),
		.stop_ok_o(stop_ok), .start_len_o(start_len));

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		xtal_i <= ~xtal_i;
		pll_cnt <= pll_cnt + 2'h1;
		if (pll_cnt == 2'h3) pll_clk_i <= ~pll_clk_i;
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task test_done;
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task hang;
		n_errors++;
		$display("BAD %0t wait ran out", $time);
		test_done;
	endtask
	task wb(input logic we, input logic sel, input logic [7:0] adr, input logic [7:0] dat);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_sel_i <= sel;
		wb_adr_i <= adr; wb_dat_i <= dat;
		i = 0;
		do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'b1 && i < 20);
		if (wb_ack_o !== 1'b1) hang;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
	endtask
	task wr(input logic [7:0] adr, input logic [7:0] dat);
		wb(1'b1, 1'b1, adr, dat);
	endtask
	function automatic int divisor(logic [7:0] s);
		if (s[7:5] == 3'h0) return int'(s[4:0]) + 1;
		return (int'(s[4:0]) + 33) << (int'(s[7:5]) - 1);
	endfunction
	task tx_start(input logic [7:0] data);
		@(posedge clk_i);
		tx_data_i <= data; tx_valid_i <= 1'b1;
		@(posedge clk_i);
		check(tx_ready_o, 1'b1);
		tx_valid_i <= 1'b0;
	endtask
	task tx_finish(input int dv, input logic [7:0] data);
		int i;
		i = 0;
		while (rx_done !== 1'b1 && i < dv * 24 + 200) begin @(posedge clk_i); i++; end
		if (rx_done !== 1'b1) hang;
		check(rx_byte, data);
		check(stop_ok, 1'b1);
		check(start_len + 2 >= 2 * dv && start_len <= 2 * dv + 2, 1'b1);
		i = 0;
		while (tx_ready_o !== 1'b1 && i < dv * 4 + 40) begin @(posedge clk_i); i++; end
		check(tx_ready_o, 1'b1);
	endtask
	task send(input logic [7:0] s, input logic [7:0] data);
		bit_cycles <= 16'(2 * divisor(s));
		tx_start(data);
		tx_finish(divisor(s), data);
	endtask
	task wait_clk(input int c);
		repeat (c) @(posedge clk_i);
	endtask

	task t_reset;
		check(txd_o, 1'b1);
		check(fb_div, 5'h17);
		check(speed, 8'hFF);
		wb(1'b0, 1'b0, ADR_SERIAL_RATE, 8'h00);
		check(rd, 8'h7A);
		wb(1'b0, 1'b0, ADR_PLL_OUT_DIV, 8'h00);
		check(rd, 8'h08);
		send(8'h7A, 8'hA5);
	endtask
	task t_rates;
		// only table settings at or under the top supported rate
		foreach (rates[k]) begin
			wr(ADR_SERIAL_RATE, rates[k]);
			send(rates[k], 8'h3B ^ {k[3:0], 4'h0});
		end
	endtask
	task t_rate_change;
		wr(ADR_SERIAL_RATE, 8'h21);
		bit_cycles <= 16'(2 * divisor(8'h21));
		tx_start(8'hC7);
		wb(1'b0, 1'b0, ADR_STATUS, 8'h00);
		check(rd, 8'h01);
		wr(ADR_SERIAL_RATE, 8'h15);
		tx_finish(divisor(8'h21), 8'hC7);
		send(8'h15, 8'h81);
	endtask
	task t_regs;
		// speed code is one flop behind the trim register
		wr(ADR_SLOW_OSC_TRIM, 8'h10);
		wait_clk(1);
		check(speed, 8'hEF);
		prev_speed = speed;
		wr(ADR_SLOW_OSC_TRIM, 8'h11);
		wait_clk(1);
		check(speed < prev_speed, 1'b1);
		wr(ADR_PLL_OUT_DIV, 8'hFE);
		check(out_div, 8'hFE);
		wr(8'h50, 8'hAA);
		wb(1'b0, 1'b0, 8'h50, 8'h00);
		check(rd, 8'h00);
		wb(1'b1, 1'b0, ADR_SLOW_OSC_TRIM, 8'h55);
		wb(1'b0, 1'b0, ADR_SLOW_OSC_TRIM, 8'h00);
		check(rd, 8'h11);
		check(trim, 8'h11);
		foreach (fb_exp[k]) begin
			wr(ADR_PLL_CTRL, {5'h00, k[0], k[1:0]});
			wait_clk(1);
			check(fb_div, fb_exp[k]);
			check(pll_power_down_o, k[0]);
		end
	endtask
	task t_mid_reset;
		rst_i <= 1'b1;
		wait_clk(2);
		rst_i <= 1'b0;
		wait_clk(2);
		check(trim, 8'h00);
		check(speed, 8'hFF);
		check(fb_div, 5'h17);
		check(pll_power_down_o, 1'b0);
		wb(1'b0, 1'b0, ADR_SERIAL_RATE, 8'h00);
		check(rd, 8'h7A);
	endtask
	task pin_is(input logic [7:0] ctrl, input logic pin, input logic oe);
		wr(ADR_PLL_CTRL, ctrl);
		wait_clk(3);
		check(clock_pin_oe_o, oe);
		if (oe) check(clock_pin_o, pin);
	endtask
	task t_pins;
		gpio_out_i <= 1'b1; gpio_oe_i <= 1'b1;
		pin_is(8'h00, 1'b1, 1'b1);
		gpio_oe_i <= 1'b0;
		pin_is(8'h00, 1'b0, 1'b0);
		pin_is(8'h28, 1'b0, 1'b1);
		pin_is(8'h38, 1'b1, 1'b1);
		pin_is(8'h30, 1'b1, 1'b0);
		pin_is(8'hC8, 1'b0, 1'b0);
		foreach (clk_codes[k]) begin
			wr(ADR_PLL_CTRL, {clk_codes[k], 4'h8});
			wait_clk(4);
			p = clock_pin_o;
			n = 0;
			repeat (64) begin
				@(posedge clk_i);
				if (clock_pin_o === 1'b1 && p === 1'b0) n++;
				p = clock_pin_o;
			end
			check(n >= clk_rises[k] - 1 && n <= clk_rises[k] + 1, 1'b1);
		end
		for (int t = 0; t < 4; t++) begin
			wr(ADR_PLL_CTRL, {4'(8 + t), 4'h8});
			wait_clk(3);
			p = clock_pin_o;
			timer_ovf_i <= 4'h1 << ((t + 1) % 4);
			wait_clk(1);
			timer_ovf_i <= 4'h0;
			wait_clk(3);
			check(clock_pin_o, p);
			timer_ovf_i <= 4'h1 << t;
			wait_clk(1);
			timer_ovf_i <= 4'h0;
			wait_clk(3);
			check(clock_pin_o, !p);
		end
	endtask

	initial begin
		n_errors = 0; n_compared = 0; rst_i = 1'b1; ce_i = 1'b1;
		wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0; wb_sel_i = 1'b0;
		wb_adr_i = 8'h00; wb_dat_i = 8'h00; xtal_i = 1'b0; pll_clk_i = 1'b0;
		pll_cnt = 2'h0; timer_ovf_i = 4'h0; gpio_out_i = 1'b0; gpio_oe_i = 1'b0;
		tx_data_i = 8'h00; tx_valid_i = 1'b0; bit_cycles = 16'h0010;
		wait_clk(6);
		rst_i <= 1'b0;
		wait_clk(2);
		t_reset;
		t_rates;
		t_rate_change;
		t_regs;
		t_mid_reset;
		t_pins;
		test_done;
	end
endmodule
`default_nettype wire

// *** tb/serial_host_model.sv ***
// Purpose: host-side receiver watching the serial transmit line
// Assumes: bit_cycles_i is one bit time in clk_i cycles; data bit 0 is one
// Notes:   resyncs on the first data edge, so the start bit length is measured
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// line and timing
	input  wire logic        txd_i,
	input  wire logic [15:0] bit_cycles_i,
	// decoded character
	output logic [7:0]       rx_byte_o,
	output logic             rx_done_o,
	output logic             stop_ok_o,
	output logic [15:0]      start_len_o
);
	int len;

	initial begin
		rx_done_o = 1'b0;
		forever begin
			@(posedge clk_i);
			rx_done_o <= 1'b0;
			if (!rst_i && txd_i === 1'b0) begin
				len = 0;
				while (txd_i === 1'b0 && len < 60000) begin
					len++;
					@(posedge clk_i);
				end
				start_len_o <= len[15:0];
				// sample mid-bit; a wrong bit time lands on the wrong bit
				repeat (bit_cycles_i / 2) @(posedge clk_i);
				rx_byte_o[0] <= txd_i;
				for (int i = 1; i < 8; i++) begin
					repeat (bit_cycles_i) @(posedge clk_i);
					rx_byte_o[i] <= txd_i;
				end
				// no parity slot: the tenth bit must already be stop
				repeat (bit_cycles_i) @(posedge clk_i);
				stop_ok_o <= (txd_i === 1'b1);
				rx_done_o <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire
